// *** logic/dvg_pkg.sv ***
// package: constants of the ds3 event vector generator
package dvg_pkg;
  // vector layout
  localparam int          VEC_W          = 16;
  localparam logic [4:0]  SOURCE_DS3     = 5'h07;
  localparam logic [1:0]  VEC_MARK       = 2'h2;
  localparam int          BIT_LAST       = 15;
  localparam int          BIT_TYPE       = 14;
  // type 1 flag positions
  localparam int          T1_CLK         = 12;
  localparam int          T1_RX_SPARE_LINK_FULL        = 11;
  localparam int          T1_TX_SPARE_LINK_EMPTY        = 10;
  localparam int          T1_LPC         = 9;
  localparam int          T1_SEC         = 8;
  localparam int          T1_NR          = 7;
  // type 0 flag positions
  localparam int          T0_AIC         = 13;
  localparam int          T0_X           = 12;
  localparam int          T0_IDLE        = 11;
  localparam int          T0_AIS         = 10;
  localparam int          T0_RED         = 9;
  localparam int          T0_LOSS        = 8;
  localparam int          T0_FAS         = 7;
  // overhead persistence
  localparam logic [1:0]  PERSIST_MF     = 2'h3;
  localparam int          NR_W           = 2;
  localparam int          X_W            = 2;
  localparam int          LPC_W          = 8;
  // timebase
  localparam int          CLK_HZ         = 200000000;
  localparam int          SEC_S          = 1;
  localparam int          SEC_CYCLES     = CLK_HZ * SEC_S;
  // apb register byte addresses
  localparam logic [7:0]  ADDR_VEC       = 8'h00;
  localparam logic [7:0]  ADDR_STATE     = 8'h04;
  localparam logic [7:0]  ADDR_LPC       = 8'h08;
  localparam logic [7:0]  ADDR_IRQ_STAT  = 8'h0c;
  localparam logic [7:0]  ADDR_IRQ_MASK  = 8'h10;
  localparam logic [7:0]  ADDR_CTRL      = 8'h14;
  // reset values
  localparam logic [1:0]  IRQ_MASK_RST   = 2'h0;
  localparam logic        CTRL_EN_RST    = 1'b1;
  // irq status bits
  localparam int          IRQ_T1         = 0;
  localparam int          IRQ_T0         = 1;
endpackage

// *** logic/dvg_persist_if.sv ***
// interface: overhead persistence filter carrier
`timescale 1ns/1ps
interface dvg_persist_if #(parameter int W = 1);
  logic         mf_tick;
  logic [W-1:0] rx_bits;
  logic [W-1:0] stable;
  logic         changed;
  modport filt (input mf_tick, input rx_bits, output stable, output changed);
  modport user (output mf_tick, output rx_bits, input stable, input changed);
endinterface // dvg_persist_if

// *** logic/dvg_persist.sv ***
// module: multiframe persistence filter for overhead bits
`timescale 1ns/1ps
module dvg_persist #(
  parameter int W = 1
) (
  input  wire logic   clk,
  input  wire logic   rst_n,
  dvg_persist_if.filt p
);
  import dvg_pkg::*;

  typedef struct packed {
    logic [W-1:0] cand;
    logic [W-1:0] stable;
    logic [1:0]   cnt;
    logic         changed;
  } dvg_pst_t;

  dvg_pst_t s, next_s;

  always_comb begin
    next_s = s;
    next_s.changed = 1'b0;
    if (p.mf_tick) begin
      if (p.rx_bits != s.cand) begin
        next_s.cand = p.rx_bits;
        next_s.cnt  = 2'h1;
      end else if (s.cnt < PERSIST_MF) begin
        next_s.cnt = s.cnt + 2'h1;
      end
      if (p.rx_bits == s.cand && s.cnt == PERSIST_MF - 2'h1 && s.cand != s.stable) begin
        next_s.stable  = s.cand;
        next_s.changed = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign p.stable  = s.stable;
  assign p.changed = s.changed;
endmodule // dvg_persist

// *** logic/dvg_top.sv ***
// module: ds3 event vector generator with apb register access
//
// Function
// - type 1 vectors have bit 14 set, bit 13 clear, bits 6:5 = 10 and the ds3 source code.
// - bit 12 of type 1 flags a change of tx or rx line clock activity, held as status.
// - bit 11 of type 1 flags that the rx spare link buffer is full.
// - bit 10 of type 1 flags that the tx spare link buffer is empty.
// - bit 9 of type 1 flags any change of received loopback codes, readable separately.
// - bit 8 of type 1 is a one second tick from a timebase counter.
// - bit 7 of type 1 flags a new national bit value stable for three multiframes.
// - a type 0 event flags a new application id bit stable for three multiframes.
// - a type 0 event flags new x overhead bits stable for three multiframes.
// - a type 0 event flags idle detection changes, state held in status.
// - a type 0 event flags alarm indication changes, state held in status.
// - a type 0 event flags red alarm changes, state held in status.
// - a type 0 event flags loss of input changes, state held in status.
// - a type 0 event flags frame alignment changes, state held in status.
// - type 0 vectors clear bit 14 and carry seven flags in 13:7, then 10 and the code.
// - the five-bit field 4:0 tells ds3 vectors from other sources.
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/1ps
module dvg_top (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  tx_clock_active,
  input  wire logic                  rx_clock_active,
  input  wire logic                  rx_spare_link_full,
  input  wire logic                  tx_spare_link_empty,
  input  wire logic [dvg_pkg::LPC_W-1:0] rx_loopback_codes,
  input  wire logic                  multiframe_tick,
  input  wire logic [dvg_pkg::NR_W-1:0]  rx_national_bits,
  input  wire logic                  rx_application_id,
  input  wire logic [dvg_pkg::X_W-1:0]   rx_x_bits,
  input  wire logic                  idle_detect,
  input  wire logic                  alarm_indication,
  input  wire logic                  red_alarm,
  input  wire logic                  loss_of_signal,
  input  wire logic                  frame_aligned,
  output logic      [15:0]           event_vector,
  output logic                       event_vector_valid,
  output logic                       irq
);
  import dvg_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // persistence filters for the overhead groups
  dvg_persist_if #(.W(NR_W)) nr_if ();
  dvg_persist_if #(.W(1))    aic_if ();
  dvg_persist_if #(.W(X_W))  x_if ();

  assign nr_if.mf_tick  = multiframe_tick;
  assign nr_if.rx_bits  = rx_national_bits;
  assign aic_if.mf_tick = multiframe_tick;
  assign aic_if.rx_bits = rx_application_id;
  assign x_if.mf_tick   = multiframe_tick;
  assign x_if.rx_bits   = rx_x_bits;

  dvg_persist #(.W(NR_W)) u_nr (.clk(pclk), .rst_n(presetn), .p(nr_if.filt));
  dvg_persist #(.W(1))    u_aic (.clk(pclk), .rst_n(presetn), .p(aic_if.filt));
  dvg_persist #(.W(X_W))  u_x (.clk(pclk), .rst_n(presetn), .p(x_if.filt));

  ////////////////////////////////////////////////////////////////////////
  // state

  function automatic logic [15:0] dvg_frame(input logic type1, input logic [6:0] flags);
    dvg_frame = {1'b0, type1, 7'h00, VEC_MARK, SOURCE_DS3};
    if (type1) begin
      dvg_frame[12:7] = flags[5:0];
    end else begin
      // seven type 0 flags in 13:7
      dvg_frame[13:7] = flags;
    end
  endfunction

  typedef struct packed {
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic [15:0]      vec;
    logic             vec_valid;
    logic             irq;
    logic [27:0]      sec_cnt;
    // previous samples for edge detection
    logic [1:0]       clk_prev;
    logic             rx_spare_link_full_prev;
    logic             tx_spare_link_empty_prev;
    logic [LPC_W-1:0] lpc_prev;
    logic [4:0]       st_prev;
    // pending flags, accumulated until emitted
    logic [5:0]       pend1;
    logic [6:0]       pend0;
    logic [1:0]       irq_stat;
    logic [1:0]       irq_mask;
    logic             enable;
    logic             started;
  } dvg_st_t;

  dvg_st_t s, next_s;

  logic [5:0] ev1;
  logic [6:0] ev0;
  logic [4:0] st_now;
  logic       rd_en;
  logic       wr_en;

  always_comb begin
    st_now = {idle_detect, alarm_indication, red_alarm, loss_of_signal, frame_aligned};
    rd_en  = psel && penable && !pwrite && !s.pready;
    wr_en  = psel && penable && pwrite && !s.pready;
    ev1 = '0;
    ev0 = '0;
    if (s.started) begin
      ev1[5] = s.clk_prev != {tx_clock_active, rx_clock_active};
      ev1[4] = rx_spare_link_full && !s.rx_spare_link_full_prev;
      ev1[3] = tx_spare_link_empty && !s.tx_spare_link_empty_prev;
      ev1[2] = s.lpc_prev != rx_loopback_codes;
      ev0[4:0] = s.st_prev ^ st_now;
    end
    ev1[1] = s.sec_cnt == 28'(SEC_CYCLES - 1);
    ev1[0] = nr_if.changed;
    ev0[6] = aic_if.changed;
    ev0[5] = x_if.changed;
  end

  always_comb begin
    next_s = s;
    next_s.started   = 1'b1;
    next_s.clk_prev  = {tx_clock_active, rx_clock_active};
    next_s.rx_spare_link_full_prev = rx_spare_link_full;
    next_s.tx_spare_link_empty_prev = tx_spare_link_empty;
    next_s.lpc_prev  = rx_loopback_codes;
    next_s.st_prev   = st_now;
    next_s.sec_cnt   = ev1[1] ? 28'h0 : s.sec_cnt + 28'h1;
    next_s.vec_valid = 1'b0;
    // type 1 wins; type 0 waits while type 1 is pending, events accumulate meanwhile
    if (s.pend1 != '0) begin
      next_s.vec       = dvg_frame(1'b1, {1'b0, s.pend1});
      next_s.vec_valid = 1'b1;
      next_s.pend1     = '0;
      next_s.irq_stat[IRQ_T1] = 1'b1;
    end else if (s.pend0 != '0) begin
      next_s.vec       = dvg_frame(1'b0, s.pend0);
      next_s.vec_valid = 1'b1;
      next_s.pend0     = '0;
      next_s.irq_stat[IRQ_T0] = 1'b1;
    end
    if (s.enable) begin
      next_s.pend1 = next_s.pend1 | ev1;
      next_s.pend0 = next_s.pend0 | ev0;
    end
    // apb slave, registered pready gives one wait state per access
    next_s.pready  = 1'b0;
    next_s.pslverr = 1'b0;
    if (rd_en || wr_en) begin
      next_s.pready = 1'b1;
      next_s.prdata = '0;
      case (paddr)
        ADDR_VEC:      next_s.prdata = {16'h0000, s.vec};
        ADDR_STATE:    next_s.prdata = {25'h0, s.clk_prev, s.st_prev};
        ADDR_LPC:      next_s.prdata = {24'h0, s.lpc_prev};
        ADDR_IRQ_STAT: begin
          next_s.prdata = {30'h0, s.irq_stat};
          // read clears; a new set in the same cycle survives
          if (rd_en) begin
            // only the bits set by this cycle's emission are kept
            next_s.irq_stat = {s.pend1 == '0 && s.pend0 != '0, s.pend1 != '0};
          end
        end
        ADDR_IRQ_MASK: begin
          next_s.prdata = {30'h0, s.irq_mask};
          if (wr_en) begin
            next_s.irq_mask = pwdata[1:0];
          end
        end
        ADDR_CTRL:     begin
          next_s.prdata = {31'h0, s.enable};
          if (wr_en) begin
            next_s.enable = pwdata[0];
          end
        end
        default:       next_s.pslverr = 1'b1;
      endcase
    end
    next_s.irq = (next_s.irq_stat & s.irq_mask) != '0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s          <= '0;
      s.irq_mask <= IRQ_MASK_RST;
      s.enable   <= CTRL_EN_RST;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  assign prdata             = s.prdata;
  assign pready             = s.pready;
  assign pslverr            = s.pslverr;
  assign event_vector       = s.vec;
  assign event_vector_valid = s.vec_valid;
  assign irq                = s.irq;
endmodule // dvg_top

// *** tb/dvg_checker.sv ***
// checker: timing and layout of emitted event vectors
`timescale 1ns/1ps
module dvg_checker
  import dvg_pkg::*;
(
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire logic [15:0]                event_vector,
  input wire logic                       event_vector_valid,
  input wire logic                       irq,
  input wire logic                       tx_clock_active,
  input wire logic                       rx_clock_active,
  input wire logic                       rx_spare_link_full,
  input wire logic                       tx_spare_link_empty,
  input wire logic [dvg_pkg::LPC_W-1:0]  rx_loopback_codes,
  input wire logic                       red_alarm,
  input wire logic                       loss_of_signal,
  input wire logic                       frame_aligned
);
  logic [15:0] v;
  logic        vv;
  assign v = event_vector;
  assign vv = event_vector_valid;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////
  t1_format_a: assert property (vv && v[14] |-> !v[15] && !v[13] && v[6:0] == 7'h47)
    else $error("type 1 layout wrong");
  t0_format_a: assert property (vv && !v[14] |-> !v[15] && v[6:0] == 7'h47)
    else $error("type 0 layout wrong");
  clk_flag_a: assert property ($changed(tx_clock_active) || $changed(rx_clock_active)
    |-> ##2 vv && v[14] && v[12]) else $error("clock flag missing");
  rx_spare_link_full_flag_a: assert property ($rose(rx_spare_link_full) |-> ##2 vv && v[14] && v[11])
    else $error("rx link flag missing");
  tx_spare_link_empty_flag_a: assert property ($rose(tx_spare_link_empty) |-> ##2 vv && v[14] && v[10])
    else $error("tx link flag missing");
  lpc_flag_a: assert property ($changed(rx_loopback_codes) |-> ##2 vv && v[14] && v[9])
    else $error("loopback flag missing");
  // type 1 has priority, so a type 0 vector may slip one cycle
  red_flag_a: assert property ($changed(red_alarm) |-> ##[2:3] vv && !v[14] && v[9])
    else $error("red flag missing");
  loss_flag_a: assert property ($changed(loss_of_signal) |-> ##[2:3] vv && !v[14] && v[8])
    else $error("loss flag missing");
  fas_flag_a: assert property ($changed(frame_aligned) |-> ##[2:3] vv && !v[14] && v[7])
    else $error("alignment flag missing");
  vec_hold_a: assert property (!vv |-> $stable(v))
    else $error("vector moved without pulse");
  cover property (vv && v[14]);
  cover property (vv && !v[14]);
  cover property ($rose(irq));
endmodule // dvg_checker

// *** tb/dvg_host_model.sv ***
// host model: counts every emitted event vector and keeps the last one
`timescale 1ns/1ps
module dvg_host_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [15:0] event_vector,
  input  wire logic        event_vector_valid,
  output logic      [15:0] seen_vec,
  output int unsigned      seen_cnt
);
  // a lost pulse shows up as a stale count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_vec <= 16'h0000;
      seen_cnt <= 0;
    end else if (event_vector_valid) begin
      seen_vec <= event_vector;
      seen_cnt <= seen_cnt + 1;
    end
  end
endmodule // dvg_host_model

// *** tb/dvg_tb_top.sv ***
// testbench top: event vector generator scenarios
`timescale 1ns/1ps
module dvg_tb_top;
  import dvg_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        mft = 1'b0, application_id_change = 1'b0, pready, pslverr, err, irq, vld;
  logic [7:0]  paddr = 8'h00, lpc = 8'h00;
  logic [1:0]  nr = 2'h0, xb = 2'h0;
  logic [3:0]  t1l = 4'h0;
  logic [4:0]  t0l = 5'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] vec, seen_vec;
  int unsigned seen_cnt;
  int          num_errors = 0, tests_run = 0, cyc = 0;

  always #2.5 pclk = ~pclk;

  dvg_top u_dvg_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_clock_active(t1l[3]), .rx_clock_active(t1l[2]),
    .rx_spare_link_full(t1l[1]), .tx_spare_link_empty(t1l[0]), .rx_loopback_codes(lpc),
    .multiframe_tick(mft), .rx_national_bits(nr), .rx_application_id(application_id_change), .rx_x_bits(xb),
    .idle_detect(t0l[4]), .alarm_indication(t0l[3]), .red_alarm(t0l[2]),
    .loss_of_signal(t0l[1]), .frame_aligned(t0l[0]), .event_vector(vec),
    .event_vector_valid(vld), .irq(irq));
  dvg_host_model u_dvg_host_model (.pclk(pclk), .presetn(presetn), .event_vector(vec),
    .event_vector_valid(vld), .seen_vec(seen_vec), .seen_cnt(seen_cnt));

  ////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      complete_run();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // request held until pready is sampled high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic exp_vec(input string nm, input logic [15:0] exp);
    int unsigned c0;
    c0 = seen_cnt;
    for (int i = 0; i < 8 && seen_cnt == c0; i++) @(posedge pclk);
    chk(nm, {16'h0, seen_vec}, {16'h0, exp});
  endtask

  task automatic tick(input logic [1:0] n, input logic a, input logic [1:0] x);
    nr <= n;
    application_id_change <= a;
    xb <= x;
    mft <= 1'b1;
    @(posedge pclk);
    mft <= 1'b0;
    @(posedge pclk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t1_events();
    for (int i = 0; i < 4; i++) begin
      t1l[3-i] <= 1'b1;
      // both line clocks share bit 12, the link flags follow below it
      exp_vec("t1 flag", 16'h4047 | (16'h1000 >> (i == 0 ? 0 : i - 1)));
      t1l[3-i] <= (i < 2);
    end
    lpc <= 8'ha5;
    exp_vec("loopback flag", 16'h4247);
    apb(1'b0, ADDR_LPC, 32'h0);
    chk("loopback reg", rd, 32'h000000a5);
  endtask

  task automatic t0_events();
    for (int i = 0; i < 5; i++) begin
      t0l[4-i] <= 1'b1;
      exp_vec("t0 flag", 16'h0047 | (16'h0800 >> i));
    end
    apb(1'b0, ADDR_STATE, 32'h0);
    chk("state reg", rd, 32'h0000007f);
  endtask

  // a value that changes before the third tick must restart the count
  task automatic overhead();
    int unsigned c0;
    c0 = seen_cnt;
    tick(2'h1, 1'b0, 2'h0);
    tick(2'h1, 1'b0, 2'h0);
    tick(2'h2, 1'b0, 2'h0);
    tick(2'h2, 1'b0, 2'h0);
    chk("early nr", seen_cnt, c0);
    tick(2'h2, 1'b0, 2'h0);
    exp_vec("nr flag", 16'h40c7);
    for (int i = 0; i < 3; i++) tick(2'h2, 1'b1, 2'h3);
    exp_vec("aic x flags", 16'h3047);
  endtask

  task automatic irq_regs();
    int unsigned c0;
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    apb(1'b0, ADDR_IRQ_MASK, 32'h0);
    chk("mask reset", rd, 32'h0);
    apb(1'b1, ADDR_IRQ_MASK, 32'h1);
    t0l[2] <= 1'b0;
    exp_vec("red flag", 16'h0247);
    chk("irq masked", {31'h0, irq}, 32'h0);
    t1l[2] <= 1'b0;
    exp_vec("clk flag", 16'h5047);
    @(posedge pclk);
    chk("irq high", {31'h0, irq}, 32'h1);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk("irq status", rd, 32'h3);
    @(posedge pclk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    apb(1'b0, ADDR_VEC, 32'h0);
    chk("last vector", rd, 32'h00005047);
    // capture off: a settled national bit change must not emit
    apb(1'b1, ADDR_CTRL, 32'h0);
    c0 = seen_cnt;
    for (int i = 0; i < 3; i++) tick(2'h3, 1'b1, 2'h3);
    repeat (4) @(posedge pclk);
    chk("capture off", seen_cnt, c0);
    apb(1'b1, ADDR_CTRL, 32'h1);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("capture on", rd, 32'h1);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped err", {31'h0, err}, 32'h1);
    chk("unmapped data", rd, 32'h0);
  endtask

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t1_events();
    t0_events();
    overhead();
    irq_regs();
    complete_run();
  end
endmodule // dvg_tb_top

bind dvg_top dvg_checker u_dvg_checker (.pclk(pclk), .presetn(presetn),
  .event_vector(event_vector), .event_vector_valid(event_vector_valid), .irq(irq),
  .tx_clock_active(tx_clock_active), .rx_clock_active(rx_clock_active),
  .rx_spare_link_full(rx_spare_link_full), .tx_spare_link_empty(tx_spare_link_empty),
  .rx_loopback_codes(rx_loopback_codes), .red_alarm(red_alarm),
  .loss_of_signal(loss_of_signal), .frame_aligned(frame_aligned));
